// File: core/cpss_consts.svh
// constants for the core port / stack / data pointer register bank
// assumes an 8-bit register address space shared with other core registers
// Operation
// RULE1 - four 8-bit port latches drive 32 quasi-bidirectional lines
// RULE2 - reset loads every port latch with all ones (input mode)
// RULE3 - port three bits 5..0 carry timer, interrupt and serial functions
// RULE4 - port three bit 1 carries serial data, or shift clock in mode zero
// RULE5 - stack pointer resets to seven; first push lands at eight
// RULE6 - push pre-increments pointer, pop post-decrements it
// RULE7 - calls and interrupts push return address; returns pop it
// RULE8 - data pointer is 16 bits, bytes at separate addresses
// RULE9 - data pointer supports 16-bit immediate load and carry increment
// RULE10 - data pointer supplies 16-bit address for data, code, indirect jumps
// RULE11 - both data pointer bytes reset to zero
// RULE12 - power control bit 1 set enters power-down
// RULE13 - power control bit 0 set enters idle
// RULE14 - power control bit 7 doubles serial baud rate
// RULE15 - power control bits 3 and 2 are plain software flags
// RULE16 - power control bits 6..4 read zero, writes ignored
// RULE17 - idle or power-down bit clears on leaving that mode
`ifndef CPSS_CONSTS_SVH
`define CPSS_CONSTS_SVH
`define CPSS_ADDR_PORT0     8'h80
`define CPSS_ADDR_SP        8'h81
`define CPSS_ADDR_DPL       8'h82
`define CPSS_ADDR_DPH       8'h83
`define CPSS_ADDR_PWR       8'h87
`define CPSS_ADDR_PORT1     8'h90
`define CPSS_ADDR_PORT2     8'hA0
`define CPSS_ADDR_PORT3     8'hB0
`define CPSS_PORT_RESET     8'hFF
`define CPSS_SP_RESET       8'h07
`define CPSS_DP_RESET       16'h0000
`define CPSS_PWR_RESET      8'h00
`define CPSS_PWR_WMASK      8'h8F
`define CPSS_PWR_BAUD_DOUBLER_BIT   7
`define CPSS_PWR_GF1_BIT    3
`define CPSS_PWR_GF0_BIT    2
`define CPSS_PWR_PD_BIT     1
`define CPSS_PWR_IDL_BIT    0
`define CPSS_P3_T1_BIT      5
`define CPSS_P3_T0_BIT      4
`define CPSS_P3_INT1_BIT    3
`define CPSS_P3_INT0_BIT    2
`define CPSS_P3_TXD_BIT     1
`define CPSS_P3_RXD_BIT     0
`endif

// File: core/cpss_pkg.sv
// types for the core port / stack / data pointer register bank
// assumes cpss_consts.svh for numeric constants
package cpss_pkg;
  typedef enum logic [2:0] {
    CPSS_STACK_NONE = 3'b001,
    CPSS_STACK_PUSH = 3'b010,
    CPSS_STACK_POP  = 3'b100
  } cpss_stack_op_type;
  typedef enum logic [2:0] {
    CPSS_PWR_RUN  = 3'b001,
    CPSS_PWR_IDLE = 3'b010,
    CPSS_PWR_DOWN = 3'b100
  } cpss_pwr_state_type;
endpackage : cpss_pkg

// File: core/cpss_port_latch.sv
// one 8-bit quasi-bidirectional port latch with pin readback
// assumes pins sampled synchronous to ref_clk; latch one lets pin float high
`timescale 1ns/100ps
`include "cpss_consts.svh"
module cpss_port_latch #(
  parameter logic [7:0] RESET_VALUE = `CPSS_PORT_RESET
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  input  wire logic [7:0] altOut,
  input  wire logic [7:0] pinIn,
  output logic      [7:0] latchQ,
  output logic      [7:0] pinOut,
  output logic      [7:0] pinOe,
  output logic      [7:0] pinSample
);
  logic [7:0] latchReg;
  logic [7:0] latchNext;
  logic [7:0] driveNext;
  logic [7:0] sampleReg;
  always_comb begin
    latchNext = wrEn ? wrData : latchReg;
    // a line drives low only when latch or alternate output asks for zero
    driveNext = latchNext & altOut; // RULE1
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latchReg  <= RESET_VALUE; // RULE2
      pinOut    <= 8'h00;
      pinOe     <= 8'h00;
      sampleReg <= 8'hFF;
    end else if (clkEn) begin
      latchReg  <= latchNext;
      pinOut    <= 8'h00;
      pinOe     <= ~driveNext;
      sampleReg <= pinIn;
    end
  end
  assign latchQ    = latchReg;
  assign pinSample = sampleReg;
endmodule : cpss_port_latch

// File: core/cpss_core_regs.sv
// core port, stack pointer, data pointer and power control registers
// assumes core register bus: one-cycle write strobe, registered read data
`timescale 1ns/100ps
`include "cpss_consts.svh"
module cpss_core_regs
  import cpss_pkg::*;
#(
  parameter int PORT_COUNT = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  output logic             regHit,
  input  wire logic        stackPush,
  input  wire logic        stackPop,
  input  wire logic [15:0] dataPtrLoadValue,
  input  wire logic        dataPtrLoad,
  input  wire logic        dataPtrInc,
  input  wire logic [7:0]  accValue,
  output logic      [7:0]  stackAddr,
  output logic      [15:0] dataPtrAddr,
  output logic      [15:0] jumpAddr,
  input  wire logic        serialTxData,
  input  wire logic        serialShiftClk,
  input  wire logic        serialModeZero,
  input  wire logic        wakeInterrupt,
  output logic             timerOneCountInput,
  output logic             timerZeroCountInput,
  output logic             externalInterruptOneLine,
  output logic             externalInterruptZeroLine,
  output logic             serialRxData,
  output logic             baudDoubler,
  output logic             haltClockRequest,
  output logic             powerDownRequest,
  input  wire logic [31:0] portPinIn,
  output logic      [31:0] portPinOut,
  output logic      [31:0] portPinOe
);
  logic [7:0]  stackPointerReg;
  logic [7:0]  stackPointerNext;
  logic [15:0] dataPointerReg;
  logic [15:0] dataPointerNext;
  logic [7:0]  powerCtrlReg;
  logic [7:0]  powerCtrlNext;
  cpss_pwr_state_type pwrStateReg;
  cpss_pwr_state_type pwrStateNext;
  cpss_stack_op_type  stackOp;
  logic [7:0]  rdDataNext;
  logic        hitNext;
  logic [7:0]  stackAddrNext;
  logic [15:0] jumpAddrNext;
  logic [3:0]  portWrEn;
  logic [3:0]  ctrlWrEn;
  logic [7:0]  portSample [4];
  logic [7:0]  portAlt [4];
  logic [7:0]  p3Sample;
  logic        txdNext;

  function automatic logic [3:0] port_select(input logic [7:0] addr);
    if (addr == `CPSS_ADDR_PORT0) begin
      port_select = 4'h1;
    end else if (addr == `CPSS_ADDR_PORT1) begin
      port_select = 4'h2;
    end else if (addr == `CPSS_ADDR_PORT2) begin
      port_select = 4'h4;
    end else if (addr == `CPSS_ADDR_PORT3) begin
      port_select = 4'h8;
    end else begin
      port_select = 4'h0;
    end
  endfunction : port_select

  // one-hot select of the non-port registers, shared by every write path
  function automatic logic [3:0] ctrl_select(input logic [7:0] addr);
    if (addr == `CPSS_ADDR_SP) begin
      ctrl_select = 4'h1;
    end else if (addr == `CPSS_ADDR_DPL) begin
      ctrl_select = 4'h2;
    end else if (addr == `CPSS_ADDR_DPH) begin
      ctrl_select = 4'h4;
    end else if (addr == `CPSS_ADDR_PWR) begin
      ctrl_select = 4'h8;
    end else begin
      ctrl_select = 4'h0;
    end
  endfunction : ctrl_select

  // pin buses, write enables and the address map are built for four ports
  if (PORT_COUNT != 4) begin : g_port_count_check
    $error("cpss_core_regs: PORT_COUNT must be 4");
  end

  always_comb begin
    portWrEn = regWr ? port_select(regAddr) : 4'h0;
    ctrlWrEn = regWr ? ctrl_select(regAddr) : 4'h0;
    // transmit line shows shift clock in serial mode zero
    txdNext  = serialModeZero ? serialShiftClk : serialTxData; // RULE4
    portAlt[0] = 8'hFF;
    portAlt[1] = 8'hFF;
    portAlt[2] = 8'hFF;
    portAlt[3] = 8'hFF;
    portAlt[3][`CPSS_P3_TXD_BIT] = txdNext; // RULE3
  end

  genvar gi;
  generate
    for (gi = 0; gi < PORT_COUNT; gi++) begin : g_port
      cpss_port_latch #(
        .RESET_VALUE (`CPSS_PORT_RESET)
      ) u_port (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .wrEn      (portWrEn[gi]),
        .wrData    (regWrData),
        .altOut    (portAlt[gi]),
        .pinIn     (portPinIn[gi*8 +: 8]),
        .latchQ    (),
        .pinOut    (portPinOut[gi*8 +: 8]),
        .pinOe     (portPinOe[gi*8 +: 8]),
        .pinSample (portSample[gi])
      ); // RULE1
    end
  endgenerate

  always_comb begin
    p3Sample = portSample[3];
  end

  // stack pointer: register write wins over a simultaneous stack operation
  always_comb begin
    if (stackPush) begin
      stackOp = CPSS_STACK_PUSH;
    end else if (stackPop) begin
      stackOp = CPSS_STACK_POP;
    end else begin
      stackOp = CPSS_STACK_NONE;
    end
    stackPointerNext = stackPointerReg;
    stackAddrNext    = stackPointerReg;
    case (stackOp)
      CPSS_STACK_PUSH: begin
        stackPointerNext = stackPointerReg + 8'h01; // RULE6
        stackAddrNext    = stackPointerReg + 8'h01; // RULE7
      end
      CPSS_STACK_POP: begin
        stackPointerNext = stackPointerReg - 8'h01; // RULE6
        stackAddrNext    = stackPointerReg; // RULE7
      end
      default: begin
        stackPointerNext = stackPointerReg;
      end
    endcase
    if (ctrlWrEn[0]) begin
      stackPointerNext = regWrData;
    end
  end

  // data pointer
  always_comb begin
    dataPointerNext = dataPointerReg;
    if (dataPtrLoad) begin
      dataPointerNext = dataPtrLoadValue; // RULE9
    end else if (dataPtrInc) begin
      dataPointerNext = dataPointerReg + 16'h0001; // RULE9
    end else if (ctrlWrEn[1]) begin
      dataPointerNext = {dataPointerReg[15:8], regWrData}; // RULE8
    end else if (ctrlWrEn[2]) begin
      dataPointerNext = {regWrData, dataPointerReg[7:0]}; // RULE8
    end
    jumpAddrNext = dataPointerNext + {8'h00, accValue}; // RULE10
  end

  // power control and mode tracking
  always_comb begin
    powerCtrlNext = powerCtrlReg;
    pwrStateNext  = pwrStateReg;
    if (ctrlWrEn[3]) begin
      powerCtrlNext = regWrData & `CPSS_PWR_WMASK; // RULE15 RULE16
    end
    case (pwrStateReg)
      CPSS_PWR_RUN: begin
        if (powerCtrlNext[`CPSS_PWR_PD_BIT]) begin
          pwrStateNext = CPSS_PWR_DOWN; // RULE12
        end else if (powerCtrlNext[`CPSS_PWR_IDL_BIT]) begin
          pwrStateNext = CPSS_PWR_IDLE; // RULE13
        end
      end
      CPSS_PWR_IDLE: begin
        if (wakeInterrupt) begin
          pwrStateNext = CPSS_PWR_RUN;
          powerCtrlNext[`CPSS_PWR_IDL_BIT] = 1'b0; // RULE17
        end
      end
      CPSS_PWR_DOWN: begin
        // only reset leaves power-down
        pwrStateNext = CPSS_PWR_DOWN;
      end
      default: begin
        pwrStateNext = CPSS_PWR_RUN;
      end
    endcase
  end

  // read decode
  always_comb begin
    hitNext    = 1'b1;
    rdDataNext = 8'h00;
    if (regAddr == `CPSS_ADDR_PORT0) begin
      rdDataNext = portSample[0];
    end else if (regAddr == `CPSS_ADDR_PORT1) begin
      rdDataNext = portSample[1];
    end else if (regAddr == `CPSS_ADDR_PORT2) begin
      rdDataNext = portSample[2];
    end else if (regAddr == `CPSS_ADDR_PORT3) begin
      rdDataNext = portSample[3];
    end else if (regAddr == `CPSS_ADDR_SP) begin
      rdDataNext = stackPointerReg;
    end else if (regAddr == `CPSS_ADDR_DPL) begin
      rdDataNext = dataPointerReg[7:0]; // RULE8
    end else if (regAddr == `CPSS_ADDR_DPH) begin
      rdDataNext = dataPointerReg[15:8]; // RULE8
    end else if (regAddr == `CPSS_ADDR_PWR) begin
      rdDataNext = powerCtrlReg & `CPSS_PWR_WMASK; // RULE16
    end else begin
      hitNext = 1'b0;
    end
    if (!regRd) begin
      rdDataNext = 8'h00;
      hitNext    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stackPointerReg <= `CPSS_SP_RESET; // RULE5
      stackAddr       <= `CPSS_SP_RESET;
    end else if (clkEn) begin
      stackPointerReg <= stackPointerNext;
      stackAddr       <= stackAddrNext;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataPointerReg <= `CPSS_DP_RESET; // RULE11
      dataPtrAddr    <= `CPSS_DP_RESET;
      jumpAddr       <= 16'h0000;
    end else if (clkEn) begin
      dataPointerReg <= dataPointerNext;
      dataPtrAddr    <= dataPointerNext; // RULE10
      jumpAddr       <= jumpAddrNext;
    end
  end

  // requests follow the next state so they rise on the edge that takes the write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerCtrlReg     <= `CPSS_PWR_RESET; // RULE17
      pwrStateReg      <= CPSS_PWR_RUN;
      baudDoubler      <= 1'b0;
      haltClockRequest <= 1'b0;
      powerDownRequest <= 1'b0;
    end else if (clkEn) begin
      powerCtrlReg     <= powerCtrlNext;
      pwrStateReg      <= pwrStateNext;
      baudDoubler      <= powerCtrlNext[`CPSS_PWR_BAUD_DOUBLER_BIT]; // RULE14
      haltClockRequest <= (pwrStateNext == CPSS_PWR_IDLE); // RULE13
      powerDownRequest <= (pwrStateNext == CPSS_PWR_DOWN); // RULE12
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
      regHit    <= 1'b0;
    end else if (clkEn) begin
      regRdData <= rdDataNext;
      regHit    <= hitNext;
    end
  end

  // alternates idle high like a released line; two cycles from pin to output
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerOneCountInput        <= 1'b1;
      timerZeroCountInput       <= 1'b1;
      externalInterruptOneLine  <= 1'b1;
      externalInterruptZeroLine <= 1'b1;
      serialRxData              <= 1'b1;
    end else if (clkEn) begin
      timerOneCountInput        <= p3Sample[`CPSS_P3_T1_BIT]; // RULE3
      timerZeroCountInput       <= p3Sample[`CPSS_P3_T0_BIT]; // RULE3
      externalInterruptOneLine  <= p3Sample[`CPSS_P3_INT1_BIT]; // RULE3
      externalInterruptZeroLine <= p3Sample[`CPSS_P3_INT0_BIT]; // RULE3
      serialRxData              <= p3Sample[`CPSS_P3_RXD_BIT]; // RULE3
    end
  end
endmodule : cpss_core_regs

// File: dv/cpss_core_regs_chk.sv
// port-level assertions on the core register bank
// assumes bound to cpss_core_regs; one clock, async active-low reset
`timescale 1ns/100ps
module cpss_core_regs_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  input wire logic [7:0]  regAddr,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic        regHit,
  input wire logic        stackPush,
  input wire logic [7:0]  stackAddr,
  input wire logic        dataPtrInc,
  input wire logic        dataPtrLoad,
  input wire logic [15:0] dataPtrAddr,
  input wire logic        wakeInterrupt,
  input wire logic        haltClockRequest,
  input wire logic        powerDownRequest
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic pwrWr;
  logic pushOnly;
  logic incOnly;
  assign pwrWr    = clkEn && regWr && regAddr == 8'h87;
  assign pushOnly = clkEn && stackPush && !(regWr && regAddr == 8'h81);
  assign incOnly  = clkEn && dataPtrInc && !dataPtrLoad && !regWr;
  property p_rsvd; clkEn && regRd && regAddr == 8'h87 |=> regHit && regRdData[6:4] == 3'h0; endproperty
  property p_unmap; clkEn && regRd && regAddr == 8'h84 |=> !regHit && regRdData == 8'h00; endproperty
  property p_push; pushOnly [*2] |=> stackAddr == $past(stackAddr) + 8'h01; endproperty
  property p_dpinc; incOnly [*2] |=> dataPtrAddr == $past(dataPtrAddr) + 16'h0001; endproperty
  property p_idle;
    pwrWr && regWrData[0] && !regWrData[1] && !wakeInterrupt && !powerDownRequest |=> haltClockRequest;
  endproperty
  property p_pd; pwrWr && regWrData[1] |=> powerDownRequest; endproperty
  property p_wake; clkEn && haltClockRequest && wakeInterrupt && !pwrWr |=> !haltClockRequest; endproperty
  property p_pdhold; powerDownRequest |=> powerDownRequest; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved power bits nonzero");
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  a_push: assert property (p_push) else $error("push step wrong");
  a_dpinc: assert property (p_dpinc) else $error("pointer step wrong");
  a_idle: assert property (p_idle) else $error("idle not entered");
  a_pd: assert property (p_pd) else $error("power-down not entered");
  a_wake: assert property (p_wake) else $error("idle not left");
  a_pdhold: assert property (p_pdhold) else $error("power-down dropped");
  c_push: cover property (pushOnly [*2]);
  c_inc: cover property (incOnly [*2]);
  c_idle: cover property (pwrWr && regWrData[0]);
endmodule : cpss_core_regs_chk
bind cpss_core_regs cpss_core_regs_chk chk (.*);

// File: dv/cpss_core_model.sv
// processor core model issuing register bus requests
// assumes tasks are entered 1 ns after a rising edge
`timescale 1ns/100ps
module cpss_core_model (
  input  wire logic       ref_clk,
  output logic      [7:0] regAddr,
  output logic            regWr,
  output logic            regRd,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData,
  input  wire logic       regHit
);
  initial begin
    regAddr = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    regWrData = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(posedge ref_clk) #1;
    regWr = 1'b0;
    // no stale data left behind
    regWrData = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge ref_clk) #1;
    regAddr = a;
    regRd = 1'b1;
    @(posedge ref_clk) #1;
    d = regRdData;
    h = regHit;
    regRd = 1'b0;
  endtask : rd
endmodule : cpss_core_model

// File: dv/cpss_core_regs_test.sv
// self-checking bench for the core register bank
// assumes external pull-ups on all 32 port lines
`timescale 1ns/100ps
module cpss_core_regs_test;
  logic        ref_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, serialTxData = 1'b1, serialShiftClk = 1'b1;
  logic        stackPush = 1'b0, stackPop = 1'b0, dataPtrLoad = 1'b0, dataPtrInc = 1'b0;
  logic        serialModeZero = 1'b0, wakeInterrupt = 1'b0, regWr, regRd, regHit, hv;
  logic        timerOneCountInput, timerZeroCountInput, externalInterruptOneLine;
  logic        externalInterruptZeroLine, serialRxData, baudDoubler, haltClockRequest, powerDownRequest;
  logic [7:0]  regAddr, regWrData, regRdData, stackAddr, rdv, accValue = 8'h00;
  logic [15:0] dataPtrAddr, jumpAddr, dataPtrLoadValue = 16'h0000;
  logic [31:0] portPinIn, portPinOut, portPinOe, ext = 32'hFFFF_FFFF;
  int          errTotal = 0, checksDone = 0;
  // released lines float to the pull-up level
  assign portPinIn = ext & ~portPinOe;
  cpss_core_regs DUT (.*);
  cpss_core_model core (.*);
  always #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    core.rd(a, rdv, hv);
    chk(rdv, e);
  endtask : rc
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic summarize;
    $display("checks %0d errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic t_reset;
    logic [7:0] a[8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'hA0, 8'hB0};
    logic [7:0] e[8] = '{8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};
    chk(portPinOe, 32'h0);
    chk({baudDoubler, haltClockRequest, powerDownRequest}, 3'b000);
    for (int i = 0; i < 8; i++) rc(a[i], e[i]);
    chk(hv, 1'b1);
    rc(8'h84, 8'h00);
    chk(hv, 1'b0);
  endtask : t_reset
  task automatic t_port;
    core.wr(8'h80, 8'h5A);
    core.wr(8'h90, 8'hA5);
    core.wr(8'hA0, 8'h0F);
    core.wr(8'hB0, 8'hFC);
    cyc(2);
    chk(portPinOe, 32'h03F0_5AA5);
    chk(portPinOut, 32'h0);
    rc(8'h90, 8'hA5);
    core.wr(8'hB0, 8'hFF);
    ext[31:24] = 8'hD6;
    cyc(3);
    chk({timerOneCountInput, timerZeroCountInput, externalInterruptOneLine,
         externalInterruptZeroLine, serialRxData}, 5'b01010);
    ext[31:24] = 8'hFF;
    serialTxData = 1'b0;
    cyc(2);
    chk(portPinOe[25], 1'b1);
    serialTxData = 1'b1;
    serialModeZero = 1'b1;
    serialShiftClk = 1'b0;
    cyc(2);
    chk(portPinOe[25], 1'b1);
    serialShiftClk = 1'b1;
    cyc(2);
    chk(portPinOe[25], 1'b0);
  endtask : t_port
  task automatic t_stack;
    core.wr(8'h81, 8'h20);
    stackPush = 1'b1;
    cyc(1);
    chk(stackAddr, 8'h21);
    cyc(1);
    chk(stackAddr, 8'h22);
    stackPush = 1'b0;
    stackPop = 1'b1;
    cyc(1);
    stackPop = 1'b0;
    chk(stackAddr, 8'h22);
    rc(8'h81, 8'h21);
    // clock enable low: this write must not land
    clkEn = 1'b0;
    core.wr(8'h81, 8'h55);
    clkEn = 1'b1;
    rc(8'h81, 8'h21);
  endtask : t_stack
  task automatic t_data_pointer;
    core.wr(8'h82, 8'hFE);
    core.wr(8'h83, 8'h12);
    dataPtrInc = 1'b1;
    cyc(2);
    dataPtrInc = 1'b0;
    chk(dataPtrAddr, 16'h1300);
    rc(8'h83, 8'h13);
    dataPtrLoadValue = 16'hABCD;
    accValue = 8'h35;
    dataPtrLoad = 1'b1;
    cyc(1);
    dataPtrLoad = 1'b0;
    chk(dataPtrAddr, 16'hABCD);
    chk(jumpAddr, 16'hAC02);
    rc(8'h82, 8'hCD);
  endtask : t_data_pointer
  task automatic t_pwr;
    core.wr(8'h87, 8'hFC);
    rc(8'h87, 8'h8C);
    chk(baudDoubler, 1'b1);
    core.wr(8'h87, 8'h8D);
    chk(haltClockRequest, 1'b1);
    wakeInterrupt = 1'b1;
    cyc(1);
    wakeInterrupt = 1'b0;
    chk(haltClockRequest, 1'b0);
    rc(8'h87, 8'h8C);
    core.wr(8'h87, 8'h8E);
    chk(powerDownRequest, 1'b1);
    wakeInterrupt = 1'b1;
    cyc(2);
    wakeInterrupt = 1'b0;
    chk(powerDownRequest, 1'b1);
    rst_n = 1'b0;
    cyc(1);
    rst_n = 1'b1;
    chk(powerDownRequest, 1'b0);
    rc(8'h87, 8'h00);
    rc(8'h81, 8'h07);
  endtask : t_pwr
  initial begin
    cyc(10);
    rst_n = 1'b1;
    t_reset();
    t_port();
    t_stack();
    t_data_pointer();
    t_pwr();
    summarize();
  end
  // whole run is under a hundred cycles
  initial begin
    #20000;
    errTotal++;
    summarize();
  end
endmodule : cpss_core_regs_test
